// File: hdl/ptc_pkg.sv
/*
 * Package of the top-level control register bank: addresses, field
 * positions, reset values and the power-sequencer state encoding.
 * Assumes nothing of its surroundings.
 */
package ptc_pkg;
	localparam logic [7:0] ADDR_LIMITS_POWER = 8'h09;
	localparam logic [7:0] ADDR_RAIL_INPUT = 8'h0A;
	localparam logic [7:0] ADDR_THRESHOLDS = 8'h0B;

	localparam int ILIM_MSB = 7;
	localparam int ILIM_LSB = 5;
	localparam int SHIP_WAKE_BIT = 4;
	localparam int PDN_REQ_BIT = 3;
	localparam int WDOG_POLICY_BIT = 2;
	localparam int POWER_GOOD_ENABLE_BIT = 0;
	localparam int ILIM_TRIM_BIT = 6;

	localparam int PREWARN_LSB = 6;
	localparam int SRC_LSB = 4;
	localparam int OVP_BIT = 2;
	localparam int IN_UV_LSB = 0;

	localparam int SYS_UV_LSB = 6;
	localparam int TSHDN_LSB = 2;
	localparam int TWARN_LSB = 0;

	localparam logic [7:0] RESET_LIMITS_POWER = 8'h41;
	localparam logic [7:0] RESET_RAIL_INPUT = 8'h89;
	localparam logic [7:0] RESET_THRESHOLDS = 8'hCE;

	localparam logic [2:0] ILIM_OFF_CODE = 3'h7;

	typedef enum logic [1:0] {
		PTC_RAILS_OFF = 2'b00,
		PTC_RAILS_ON = 2'b01,
		PTC_RAILS_DOWN = 2'b10
	} ptc_rail_e;
endpackage

// File: hdl/ptc_regs_if.sv
/*
 * Interface between the register store and the sequencing top: register
 * access strobes and the stored register contents.
 * Assumes one clock owned by the instantiating module.
 */
`timescale 1ns/1ps
interface ptc_regs_if;
	logic wr_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic ilim_trim;
	logic [7:0] ctl0;
	logic [7:0] ctl1;
	logic [7:0] ctl2;
	modport store (input wr_en, addr, wdata, ilim_trim,
		output ctl0, ctl1, ctl2);
	modport user (output wr_en, addr, wdata, ilim_trim,
		input ctl0, ctl1, ctl2);
endinterface

// File: hdl/ptc_reg_store.sv
/*
 * Three byte-wide read-write control registers with their reset values.
 * Assumes the write strobe is synchronous to clk_i and the trim level is
 * stable while reset_i is high.
 */
`timescale 1ns/1ps
module ptc_reg_store (
	input wire logic clk_i,
	input wire logic reset_i,
	ptc_regs_if.store regs
);
	import ptc_pkg::*;

	typedef struct packed {
		logic [7:0] ctl0;
		logic [7:0] ctl1;
		logic [7:0] ctl2;
	} ptc_store_s;

	ptc_store_s state;
	ptc_store_s next_state;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	always_comb begin
		next_state = state;
		if (regs.wr_en && hit(regs.addr, ADDR_LIMITS_POWER)) begin
			next_state.ctl0 = regs.wdata;
		end
		if (regs.wr_en && hit(regs.addr, ADDR_RAIL_INPUT)) begin
			next_state.ctl1 = regs.wdata;
		end
		if (regs.wr_en && hit(regs.addr, ADDR_THRESHOLDS)) begin
			next_state.ctl2 = regs.wdata;
		end
		if (reset_i) begin
			next_state.ctl0 = RESET_LIMITS_POWER;
			// The middle current-limit bit alone follows the trim level.
			next_state.ctl0[ILIM_TRIM_BIT] = regs.ilim_trim;
			next_state.ctl1 = RESET_RAIL_INPUT;
			next_state.ctl2 = RESET_THRESHOLDS;
		end
	end

	always_ff @(posedge clk_i) begin
		state <= next_state;
	end

	assign regs.ctl0 = state.ctl0;
	assign regs.ctl1 = state.ctl1;
	assign regs.ctl2 = state.ctl2;
endmodule

// File: hdl/ptc_top.sv
/*
 * Top-level control register bank with the power-up, power-down and
 * watchdog-expiry policy it drives.
 * Assumes register accesses come from a serial target port on clk_i;
 * supply-attach, key and watchdog inputs are asynchronous pins.
 */
`timescale 1ns/1ps
// Function
// - Bits 7:5 of register 09h hold current limit code, reset 010, 111 off.
// - Only the middle limit bit resets from trim, allowing reset code 000.
// - Wake bit 0: supply attach enables charging and powers up all rails.
// - Wake bit 1: supply attach charges only; key falling edge powers up.
// - Writing power-down bit 1 starts power-down; 0 starts nothing.
// - After power-down by that bit, supply attach does not power up.
// - Watchdog expiry, policy 0: reset low, keep charging, rails to mode 0.
// - Watchdog expiry, policy 1: reset low, stop charging, rails to mode 0.
// - Power-good enable resets 1; clearing it forces all output-ok low.
// - Register 0Ah bits 7:6: system-rail prewarning code, reset 10.
// - Bits 5:4: system-rail source select, reset 00.
// - Bit 2: input overvoltage select, reset 0.
// - Bits 1:0: input undervoltage code, reset 01.
// - Register 0Bh bits 7:6: system-rail undervoltage code, reset 11.
// - Bits 4:2: thermal shutdown code, reset 011, 111 reserved.
// - Bits 1:0: die temperature warning code, reset 10.
// - All three registers read back the last value written.
module ptc_top (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_hit_o,
	input wire logic ilim_trim_i,
	input wire logic supply_attach_i,
	input wire logic power_key_n_i,
	input wire logic watchdog_expired_i,
	input wire logic [3:0] rail_comparator_ok_i,
	output logic [3:0] rail_output_ok_o,
	output logic charge_enable_o,
	output logic power_up_start_o,
	output logic power_down_start_o,
	output logic rails_to_mode0_o,
	output logic system_reset_out_n_o,
	output logic power_good_enable_o,
	output logic [2:0] input_current_limit_code_o,
	output logic input_current_limit_off_o,
	output logic [1:0] system_rail_prewarn_code_o,
	output logic [1:0] system_rail_source_code_o,
	output logic input_overvoltage_code_o,
	output logic [1:0] input_undervoltage_code_o,
	output logic [1:0] system_rail_undervoltage_code_o,
	output logic [2:0] thermal_shutdown_code_o,
	output logic [1:0] die_temp_warning_code_o,
	output ptc_pkg::ptc_rail_e rail_state_o
);
	import ptc_pkg::*;

	typedef struct packed {
		logic [1:0] attach_sync;
		logic [1:0] key_sync;
		logic [1:0] wdog_sync;
		logic attach_prev;
		logic key_prev;
		logic wdog_prev;
		logic powered_down;
		ptc_rail_e rails;
		logic charging;
		logic up_pulse;
		logic down_pulse;
		logic mode0_pulse;
		logic sys_reset_n;
		logic [3:0] ok;
		logic [7:0] rdata;
		logic hit;
	} ptc_top_s;

	ptc_top_s state;
	ptc_top_s next_state;
	ptc_regs_if regs ();

	logic [7:0] ctl0;
	logic [7:0] ctl1;
	logic [7:0] ctl2;
	logic attach_rise;
	logic key_fall;
	logic wdog_rise;
	logic pdn_write;

	assign regs.wr_en = reg_wr_i;
	assign regs.addr = reg_addr_i;
	assign regs.wdata = reg_wdata_i;
	assign regs.ilim_trim = ilim_trim_i;
	assign ctl0 = regs.ctl0;
	assign ctl1 = regs.ctl1;
	assign ctl2 = regs.ctl2;

	ptc_reg_store u_store (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.regs(regs.store)
	);

	assign attach_rise = state.attach_sync[1] && !state.attach_prev;
	assign key_fall = !state.key_sync[1] && state.key_prev;
	assign wdog_rise = state.wdog_sync[1] && !state.wdog_prev;
	assign pdn_write = reg_wr_i && (reg_addr_i == ADDR_LIMITS_POWER) &&
		reg_wdata_i[PDN_REQ_BIT];

	always_comb begin
		next_state = state;
		next_state.attach_sync = {state.attach_sync[0], supply_attach_i};
		next_state.key_sync = {state.key_sync[0], power_key_n_i};
		next_state.wdog_sync = {state.wdog_sync[0], watchdog_expired_i};
		next_state.attach_prev = state.attach_sync[1];
		next_state.key_prev = state.key_sync[1];
		next_state.wdog_prev = state.wdog_sync[1];
		next_state.up_pulse = 1'b0;
		next_state.down_pulse = 1'b0;
		next_state.mode0_pulse = 1'b0;
		if (!state.attach_sync[1]) begin
			next_state.charging = 1'b0;
		end
		if (attach_rise) begin
			next_state.charging = 1'b1;
		end
		case (state.rails)
			PTC_RAILS_OFF: begin
				if ((attach_rise && !ctl0[SHIP_WAKE_BIT] &&
					!state.powered_down) || key_fall) begin
					next_state.rails = PTC_RAILS_ON;
					next_state.up_pulse = 1'b1;
					next_state.powered_down = 1'b0;
				end
			end
			PTC_RAILS_ON: begin
				if (pdn_write) begin
					next_state.rails = PTC_RAILS_DOWN;
					next_state.down_pulse = 1'b1;
				end
			end
			PTC_RAILS_DOWN: begin
				next_state.rails = PTC_RAILS_OFF;
				next_state.powered_down = 1'b1;
			end
			default: begin
				next_state.rails = PTC_RAILS_OFF;
			end
		endcase
		if (wdog_rise) begin
			next_state.sys_reset_n = 1'b0;
			next_state.mode0_pulse = 1'b1;
			if (ctl0[WDOG_POLICY_BIT]) begin
				next_state.charging = 1'b0;
			end
		end else if (!state.wdog_sync[1]) begin
			next_state.sys_reset_n = 1'b1;
		end
		if (ctl0[POWER_GOOD_ENABLE_BIT]) begin
			next_state.ok = rail_comparator_ok_i;
		end else begin
			next_state.ok = 4'h0;
		end
		next_state.hit = 1'b1;
		case (reg_addr_i)
			ADDR_LIMITS_POWER: next_state.rdata = ctl0;
			ADDR_RAIL_INPUT: next_state.rdata = ctl1;
			ADDR_THRESHOLDS: next_state.rdata = ctl2;
			default: begin
				next_state.rdata = 8'h00;
				next_state.hit = 1'b0;
			end
		endcase
		if (reset_i) begin
			next_state = '0;
			next_state.key_sync = 2'b11;
			next_state.key_prev = 1'b1;
			next_state.sys_reset_n = 1'b1;
			next_state.rails = PTC_RAILS_OFF;
		end
	end

	always_ff @(posedge clk_i) begin
		state <= next_state;
	end

	assign reg_rdata_o = state.rdata;
	assign reg_hit_o = state.hit;
	assign rail_output_ok_o = state.ok;
	assign charge_enable_o = state.charging;
	assign power_up_start_o = state.up_pulse;
	assign power_down_start_o = state.down_pulse;
	assign rails_to_mode0_o = state.mode0_pulse;
	assign system_reset_out_n_o = state.sys_reset_n;
	assign rail_state_o = state.rails;
	assign power_good_enable_o = ctl0[POWER_GOOD_ENABLE_BIT];
	assign input_current_limit_code_o = ctl0[ILIM_MSB:ILIM_LSB];
	assign input_current_limit_off_o =
		(ctl0[ILIM_MSB:ILIM_LSB] == ILIM_OFF_CODE);
	assign system_rail_prewarn_code_o =
		ctl1[PREWARN_LSB+1:PREWARN_LSB];
	assign system_rail_source_code_o = ctl1[SRC_LSB+1:SRC_LSB];
	assign input_overvoltage_code_o = ctl1[OVP_BIT];
	assign input_undervoltage_code_o = ctl1[IN_UV_LSB+1:IN_UV_LSB];
	assign system_rail_undervoltage_code_o =
		ctl2[SYS_UV_LSB+1:SYS_UV_LSB];
	assign thermal_shutdown_code_o = ctl2[TSHDN_LSB+2:TSHDN_LSB];
	assign die_temp_warning_code_o = ctl2[TWARN_LSB+1:TWARN_LSB];
endmodule

// File: testbench/ptc_host_model.sv
/*
 * Host model that writes and reads the bank one byte at a time.
 * Assumes the bench supplies the clock and calls the tasks.
 */
`timescale 1ns/1ps
module ptc_host_model (
	input wire logic clk_i,
	output logic reg_wr_o,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i,
	input wire logic reg_hit_i
);
	initial begin
		reg_wr_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i) #1;
		reg_wr_o = 1'b1;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(posedge clk_i) #1;
		reg_wr_o = 1'b0;
		reg_wdata_o = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [8:0] r);
		@(posedge clk_i) #1;
		reg_addr_o = a;
		@(posedge clk_i) #1;
		r = {reg_hit_i, reg_rdata_i};
	endtask
endmodule

// File: testbench/ptc_top_sva.sv
/*
 * Checker of the control bank at the top module's ports.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module ptc_top_sva import ptc_pkg::*; (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic reg_hit_o,
	input wire logic [3:0] rail_output_ok_o,
	input wire logic power_good_enable_o,
	input wire logic [2:0] input_current_limit_code_o,
	input wire logic input_current_limit_off_o,
	input wire logic power_up_start_o,
	input wire logic power_down_start_o,
	input wire logic rails_to_mode0_o,
	input wire logic system_reset_out_n_o,
	input wire ptc_rail_e rail_state_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	property p_ilim_off;
		input_current_limit_off_o == (input_current_limit_code_o == 3'h7);
	endproperty
	a_ilim_off: assert property (p_ilim_off) else $error("limit off");
	property p_ok_forced;
		!power_good_enable_o ##1 !power_good_enable_o |-> rail_output_ok_o == 0;
	endproperty
	a_ok_forced: assert property (p_ok_forced) else $error("ok bits");
	property p_pdn_from_on;
		power_down_start_o |-> $past(rail_state_o) == PTC_RAILS_ON;
	endproperty
	a_pdn_from_on: assert property (p_pdn_from_on) else $error("pdn");
	property p_pdn_seq;
		power_down_start_o |->
			rail_state_o == PTC_RAILS_DOWN ##1 rail_state_o == PTC_RAILS_OFF;
	endproperty
	a_pdn_seq: assert property (p_pdn_seq) else $error("pdn order");
	property p_readback;
		reg_wr_i && reg_addr_i inside {8'h09, 8'h0A, 8'h0B} ##1
			!reg_wr_i && $stable(reg_addr_i) |=>
			reg_rdata_o == $past(reg_wdata_i, 2);
	endproperty
	a_readback: assert property (p_readback) else $error("readback");
	property p_unmapped;
		!(reg_addr_i inside {8'h09, 8'h0A, 8'h0B}) |=>
			!reg_hit_o && reg_rdata_o == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped");
	property p_mode0_reset;
		rails_to_mode0_o |-> ##[0:1] !system_reset_out_n_o;
	endproperty
	a_mode0_reset: assert property (p_mode0_reset) else $error("rst");
	property p_up_state;
		power_up_start_o |-> ##[0:1] rail_state_o == PTC_RAILS_ON;
	endproperty
	a_up_state: assert property (p_up_state) else $error("power up");
endmodule
bind ptc_top ptc_top_sva u_sva (.clk_i, .reset_i, .reg_wr_i, .reg_addr_i,
	.reg_wdata_i, .reg_rdata_o, .reg_hit_o, .rail_output_ok_o,
	.power_good_enable_o, .input_current_limit_code_o,
	.input_current_limit_off_o, .power_up_start_o, .power_down_start_o,
	.rails_to_mode0_o, .system_reset_out_n_o, .rail_state_o);

// File: testbench/tb.sv
/*
 * Self-checking bench of the control bank and its power policy.
 * Assumes the host model and the checker are compiled before it.
 */
`timescale 1ns/1ps
module tb;
	import ptc_pkg::*;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic trim = 1'b1, supply = 1'b0, key_n = 1'b1, wdog = 1'b0;
	logic [3:0] cmp = 4'h0;
	logic wr, hit, chg, pup, m0, rst_n, got;
	logic [7:0] addr, wdata, rdata, m;
	logic [8:0] r, f;
	logic [2:0] ilc, tsd;
	logic ilo, pge, ovp;
	logic [1:0] pw, src, iuv, suv, twn;
	logic [3:0] ok;
	logic [7:0] sh [3];
	ptc_rail_e st;
	int failures = 0, checks = 0, cyc = 0;
	always #10 clk_i = ~clk_i;
	ptc_host_model u_host (.clk_i(clk_i), .reg_wr_o(wr), .reg_addr_o(addr),
		.reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_hit_i(hit));
	ptc_top u_dut (.clk_i(clk_i), .reset_i(reset_i), .reg_wr_i(wr),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.reg_hit_o(hit), .ilim_trim_i(trim), .supply_attach_i(supply),
		.power_key_n_i(key_n), .watchdog_expired_i(wdog),
		.rail_comparator_ok_i(cmp), .rail_output_ok_o(ok),
		.charge_enable_o(chg),
		.power_up_start_o(pup), .power_down_start_o(), .rails_to_mode0_o(m0),
		.system_reset_out_n_o(rst_n), .power_good_enable_o(pge),
		.input_current_limit_code_o(ilc), .input_current_limit_off_o(ilo),
		.system_rail_prewarn_code_o(pw), .system_rail_source_code_o(src),
		.input_overvoltage_code_o(ovp), .input_undervoltage_code_o(iuv),
		.system_rail_undervoltage_code_o(suv), .thermal_shutdown_code_o(tsd),
		.die_temp_warning_code_o(twn), .rail_state_o(st));
	task automatic stop_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			stop_test();
		end
	end
	task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	function automatic logic [7:0] rst_val(input int i, input logic t);
		case (i)
			0: return {1'b0, t, 6'b000001};
			1: return {2'b10, 2'b00, 1'b1, 1'b0, 2'b01};
			default: return {2'b11, 1'b0, 3'b011, 2'b10};
		endcase
	endfunction
	function automatic logic [8:0] exp_f(input int i, input logic [7:0] v);
		case (i)
			0: return {4'h0, v[7:5], v[7:5] == 3'h7, v[0]};
			1: return {2'b00, v[7:4], v[2:0]};
			default: return {2'b00, v[7:6], v[4:0]};
		endcase
	endfunction
	task automatic wait_up(input bit mode0);
		got = 1'b0;
		repeat (12) begin
			@(posedge clk_i) #1;
			if ((mode0 ? m0 : pup) === 1'b1) got = 1'b1;
		end
	endtask
	task automatic pulse_reset();
		@(posedge clk_i) #1 reset_i = 1'b1;
		@(posedge clk_i) #1 reset_i = 1'b0;
	endtask
	initial begin
		void'($urandom(32'h4745AF02));
		repeat (10) @(posedge clk_i);
		#1 reset_i = 1'b0;
		repeat (2) begin
			for (int i = 0; i < 3; i++) begin
				u_host.rd(8'h09 + 8'(i), r);
				chk("reset", {1'b1, rst_val(i, trim)}, r);
			end
			trim = 1'b0;
			pulse_reset();
		end
		for (int j = 0; j < 3; j++) begin
			sh[j] = rst_val(j, 1'b0);
		end
		for (int k = 0; k < 24; k++) begin
			int i;
			i = (k < 3) ? k : $urandom_range(2, 0);
			m = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
			cmp = 4'($urandom);
			u_host.wr(8'h09 + 8'(i), m);
			u_host.wr(8'h0C + 8'(k), ~m);
			u_host.rd(8'h09 + 8'(i), r);
			chk("readback", {1'b1, m}, r);
			sh[i] = m;
			if (i == 0) begin
				f = {4'h0, ilc, ilo, pge};
			end else if (i == 1) begin
				f = {2'b00, pw, src, ovp, iuv};
			end else begin
				f = {2'b00, suv, tsd, twn};
			end
			chk("field", exp_f(i, m), f);
			chk("ok", {5'h00, sh[0][0] ? cmp : 4'h0}, {5'h00, ok});
		end
		u_host.rd(8'h08, r);
		chk("unmapped", 9'h000, r);
		u_host.wr(8'h09, 8'h51);
		supply = 1'b1;
		wait_up(0);
		chk("attach with wake bit set", 9'h000, {8'h00, got});
		key_n = 1'b0;
		wait_up(0);
		chk("key power up", 9'h001, {8'h00, got});
		{key_n, supply} = 2'b10;
		pulse_reset();
		supply = 1'b1;
		wait_up(0);
		chk("attach power up", 9'h001, {8'h00, got});
		chk("charging", 9'h001, {8'h00, chg});
		u_host.wr(8'h09, 8'h09);
		repeat (4) @(posedge clk_i);
		chk("rails down", {7'h00, PTC_RAILS_OFF}, {7'h00, st});
		supply = 1'b0;
		repeat (6) @(posedge clk_i);
		supply = 1'b1;
		wait_up(0);
		chk("attach after down", 9'h000, {8'h00, got});
		key_n = 1'b0;
		wait_up(0);
		key_n = 1'b1;
		for (int p = 0; p < 2; p++) begin
			u_host.wr(8'h09, 8'h41 | 8'(p << 2));
			wdog = 1'b1;
			wait_up(1);
			chk("mode0", 9'h001, {8'h00, got});
			chk("sys reset", 9'h000, {8'h00, rst_n});
			chk("charge", {8'h00, p == 0}, {8'h00, chg});
			wdog = 1'b0;
			repeat (6) @(posedge clk_i);
		end
		stop_test();
	end
endmodule
